// ===== core/ov_fault_handler.sv
`timescale 1ns/10ps
// Summary of operation
// - Hold overvoltage threshold as 16-bit unsigned, exponent minus five.
// - Fault flag only when measured voltage strictly exceeds threshold.
// - Response 00 keeps the output converting on overvoltage.
// - Response 10 disables output, then follows retry count bits 5:3.
// - Retry count 000 makes no restart; stay off until cleared.
// - Retry counts 001 to 110 give exactly that many restart attempts.
// - When all attempts fail, stay off until the fault is cleared.
// - Retry count 111 retries without limit.
// - Commanded off, bias loss or other fault stop retrying.
// - Retry delay is bits 2:0 times 200 ms.
// - Delay runs from start of one attempt to start of the next.
module ov_fault_handler import ovf_pkg::*; #(
  parameter int UNIT_CYCLES = RETRY_UNIT_CYCLES
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic cmd_wr,
  input wire logic cmd_rd,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  output logic [15:0] rd_data_reg,
  output logic rd_valid_reg,
  input wire logic [15:0] vout_meas,
  input wire logic control_pin_on,
  input wire logic operation_off,
  input wire logic bias_lost,
  input wire logic other_fault,
  input wire logic fault_clear,
  output logic output_enable_reg,
  output logic ov_fault_flag_reg,
  output logic [2:0] attempts_reg
);
  logic [15:0] limit_reg;
  logic [15:0] limit_next;
  logic [7:0] action_reg;
  logic [7:0] action_next;
  logic [15:0] rd_data_next;
  logic rd_valid_next;
  logic ctrl_meta_reg;
  logic ctrl_sync_reg;
  fault_state_e state_reg;
  fault_state_e state_next;
  logic [2:0] attempts_next;
  logic output_enable_next;
  logic ov_fault_flag_next;
  logic ov_now;
  logic off_req;
  logic timer_start;
  logic timer_done;
  logic [1:0] resp;
  logic [2:0] retries;
  logic [2:0] delay_units;
  logic out_of_tries;

  assign resp = action_reg[ACT_RESP_HI:ACT_RESP_LO];
  assign retries = action_reg[ACT_RETRY_HI:ACT_RETRY_LO];
  assign delay_units = action_reg[ACT_DELAY_HI:ACT_DELAY_LO];
  // Equality never trips, so the threshold resolution sets the real level
  assign ov_now = vout_meas > limit_reg;
  assign off_req = operation_off || !ctrl_sync_reg || bias_lost
                   || other_fault;
  assign out_of_tries = (retries != RETRY_FOREVER)
                        && (attempts_reg >= retries);

  // Register access by command code
  always_comb begin
    limit_next = limit_reg;
    action_next = action_reg;
    rd_data_next = rd_data_reg;
    rd_valid_next = cmd_rd;
    if (cmd_wr && cmd_code == CMD_OV_LIMIT) begin
      limit_next = cmd_wdata;
    end
    if (cmd_wr && cmd_code == CMD_OV_ACTION) begin
      action_next = cmd_wdata[7:0];
    end
    if (cmd_rd) begin
      case (cmd_code)
        CMD_OV_LIMIT: rd_data_next = limit_reg;
        CMD_OV_ACTION: rd_data_next = {8'h00, action_reg};
        default: rd_data_next = RD_DATA_NONE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      limit_reg <= OV_LIMIT_RESET;
      action_reg <= OV_ACTION_RESET;
      rd_data_reg <= RD_DATA_NONE;
      rd_valid_reg <= 1'b0;
      ctrl_meta_reg <= 1'b0;
      ctrl_sync_reg <= 1'b0;
    end else begin
      limit_reg <= limit_next;
      action_reg <= action_next;
      rd_data_reg <= rd_data_next;
      rd_valid_reg <= rd_valid_next;
      // Remote pin is asynchronous: two stages before use
      ctrl_meta_reg <= control_pin_on;
      ctrl_sync_reg <= ctrl_meta_reg;
    end
  end

  // Fault sequencing
  always_comb begin
    state_next = state_reg;
    attempts_next = attempts_reg;
    timer_start = 1'b0;
    // Set wins over a clear in the same cycle
    ov_fault_flag_next = ov_now || (ov_fault_flag_reg && !fault_clear);
    if (off_req) begin
      state_next = ST_OFF;
      attempts_next = ATTEMPTS_ZERO;
    end else if (fault_clear && state_reg != ST_RUN) begin
      state_next = ST_RUN;
      attempts_next = ATTEMPTS_ZERO;
    end else begin
      if (fault_clear) begin
        attempts_next = ATTEMPTS_ZERO;
      end
      case (state_reg)
        ST_RUN: begin
          // Reserved responses are treated like ignore
          if (ov_now && resp == RESP_DISABLE) begin
            if (retries == RETRY_NONE || out_of_tries) begin
              state_next = ST_LATCHED;
            end else begin
              state_next = ST_HOLDOFF;
              timer_start = 1'b1;
            end
          end
        end
        ST_HOLDOFF: begin
          if (timer_done) begin
            state_next = ST_ATTEMPT;
            timer_start = 1'b1;
            if (retries != RETRY_FOREVER) begin
              attempts_next = attempts_reg + ATTEMPT_STEP;
            end
          end
        end
        ST_ATTEMPT: begin
          if (ov_now) begin
            // Timer keeps running from the attempt start
            if (out_of_tries) begin
              state_next = ST_LATCHED;
            end else begin
              state_next = ST_HOLDOFF;
            end
          end else if (timer_done) begin
            state_next = ST_RUN;
          end
        end
        ST_LATCHED: state_next = ST_LATCHED;
        ST_OFF: state_next = ST_RUN;
        default: state_next = ST_OFF;
      endcase
    end
    output_enable_next = (state_next == ST_RUN)
                         || (state_next == ST_ATTEMPT);
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      state_reg <= ST_OFF;
      attempts_reg <= ATTEMPTS_ZERO;
      output_enable_reg <= 1'b0;
      ov_fault_flag_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      attempts_reg <= attempts_next;
      output_enable_reg <= output_enable_next;
      ov_fault_flag_reg <= ov_fault_flag_next;
    end
  end

  retry_delay_timer #(
    .UNIT_CYCLES(UNIT_CYCLES),
    .CNT_W(TICK_W)
  ) u_delay (
    .mclk(mclk),
    .reset_n(reset_n),
    .start(timer_start),
    .units(delay_units),
    .done(timer_done)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  limit_store_a: assert property (
    cmd_wr && cmd_code == CMD_OV_LIMIT |=> limit_reg == $past(cmd_wdata))
    else $error("threshold write not stored");
  strict_compare_a: assert property (
    !ov_fault_flag_reg && vout_meas <= limit_reg |=> !ov_fault_flag_reg)
    else $error("fault flag set without exceeding threshold");
  ignore_keeps_a: assert property (
    state_reg == ST_RUN && resp == RESP_IGNORE && !off_req
    |=> output_enable_reg)
    else $error("output dropped while fault ignored");
  fault_disables_a: assert property (
    state_reg == ST_RUN && ov_now && resp == RESP_DISABLE
    |=> !output_enable_reg)
    else $error("output not disabled on overvoltage");
  no_retry_latch_a: assert property (
    state_reg == ST_RUN && ov_now && resp == RESP_DISABLE
    && retries == RETRY_NONE && !off_req && !fault_clear
    |=> state_reg == ST_LATCHED)
    else $error("no-retry setting did not latch off");
  attempt_bound_a: assert property (
    state_reg == ST_ATTEMPT && retries != RETRY_FOREVER
    && $stable(action_reg) |-> attempts_reg <= retries)
    else $error("more attempts than the retry setting");
  latched_stays_a: assert property (
    state_reg == ST_LATCHED && !fault_clear && !off_req
    |=> state_reg == ST_LATCHED && !output_enable_reg)
    else $error("latched output came back without clear");
  forever_retry_a: assert property (
    state_reg == ST_ATTEMPT && ov_now && retries == RETRY_FOREVER
    && !off_req && !fault_clear |=> state_reg == ST_HOLDOFF)
    else $error("continuous retry stopped");
  off_stops_a: assert property (
    off_req |=> state_reg == ST_OFF ##0 !output_enable_reg)
    else $error("command off did not stop the output");
  start_anchor_a: assert property (
    state_next == ST_ATTEMPT && state_reg != ST_ATTEMPT |-> timer_start)
    else $error("delay not restarted at attempt start");
  count_reset_a: assert property (
    off_req || fault_clear |=> attempts_reg == ATTEMPTS_ZERO)
    else $error("attempt counter not reset");
endmodule : ov_fault_handler

// ===== common/ovf_pkg.sv
package ovf_pkg;
  // Command codes of the two registers
  localparam logic [7:0] CMD_OV_LIMIT = 8'h40;
  localparam logic [7:0] CMD_OV_ACTION = 8'h41;
  // Reset values: highest limit never trips, action disables without retry
  localparam logic [15:0] OV_LIMIT_RESET = 16'hFFFF;
  localparam logic [7:0] OV_ACTION_RESET = 8'h80;
  localparam logic [15:0] RD_DATA_NONE = 16'h0000;
  // Threshold format: unsigned mantissa, fixed exponent
  localparam int OV_LIMIT_W = 16;
  localparam int OV_LIMIT_EXP = -5;
  // Action field layout
  localparam int ACT_RESP_HI = 7;
  localparam int ACT_RESP_LO = 6;
  localparam int ACT_RETRY_HI = 5;
  localparam int ACT_RETRY_LO = 3;
  localparam int ACT_DELAY_HI = 2;
  localparam int ACT_DELAY_LO = 0;
  localparam logic [1:0] RESP_IGNORE = 2'h0;
  localparam logic [1:0] RESP_DISABLE = 2'h2;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] RETRY_FOREVER = 3'h7;
  localparam logic [2:0] ATTEMPTS_ZERO = 3'h0;
  localparam logic [2:0] ATTEMPT_STEP = 3'h1;
  // Retry delay unit in clock cycles
  localparam int CLK_PERIOD_NS = 50;
  localparam int RETRY_UNIT_MS = 200;
  localparam int NS_PER_MS = 1000000;
  localparam int RETRY_UNIT_CYCLES = RETRY_UNIT_MS * NS_PER_MS / CLK_PERIOD_NS;
  localparam int TICK_W = 22;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_HOLDOFF = 3'b001,
    ST_ATTEMPT = 3'b010,
    ST_LATCHED = 3'b011,
    ST_OFF = 3'b100
  } fault_state_e;
endpackage : ovf_pkg

// ===== core/retry_delay_timer.sv
`timescale 1ns/10ps
module retry_delay_timer import ovf_pkg::*; #(
  parameter int UNIT_CYCLES = RETRY_UNIT_CYCLES,
  parameter int CNT_W = TICK_W
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [2:0] units,
  output logic done
);
  logic [CNT_W-1:0] tick_reg;
  logic [CNT_W-1:0] tick_next;
  logic [2:0] left_reg;
  logic [2:0] left_next;
  logic done_reg;
  logic done_next;
  localparam logic [CNT_W-1:0] TICK_LAST = CNT_W'(UNIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] TICK_ZERO = '0;
  localparam logic [CNT_W-1:0] TICK_STEP = CNT_W'(1);

  always_comb begin
    tick_next = tick_reg;
    left_next = left_reg;
    done_next = done_reg;
    if (start) begin
      // Counting from one lets the state step exactly on the delay
      // boundary; this needs UNIT_CYCLES of at least two
      tick_next = TICK_STEP;
      left_next = units;
      // A zero delay still costs one cycle so the sequence always advances
      done_next = (units == RETRY_NONE);
    end else if (!done_reg) begin
      if (tick_reg == TICK_LAST) begin
        tick_next = TICK_ZERO;
        left_next = left_reg - ATTEMPT_STEP;
        done_next = (left_reg == ATTEMPT_STEP);
      end else begin
        tick_next = tick_reg + TICK_STEP;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      tick_reg <= TICK_ZERO;
      left_reg <= RETRY_NONE;
      done_reg <= 1'b1;
    end else begin
      tick_reg <= tick_next;
      left_reg <= left_next;
      done_reg <= done_next;
    end
  end

  assign done = done_reg;

  zero_delay_a: assert property (@(posedge mclk) disable iff (!reset_n)
    start && units == RETRY_NONE |=> done_reg)
    else $error("zero delay did not finish in one cycle");
  nonzero_wait_a: assert property (@(posedge mclk) disable iff (!reset_n)
    start && units != RETRY_NONE |=> !done_reg [*2])
    else $error("retry delay finished too early");
endmodule : retry_delay_timer

// ===== verification/pmbus_host_model.sv
`timescale 1ns/10ps
module pmbus_host_model (
  input wire logic mclk,
  output logic cmd_wr,
  output logic cmd_rd,
  output logic [7:0] cmd_code,
  output logic [15:0] cmd_wdata,
  input wire logic [15:0] rd_data_reg,
  input wire logic rd_valid_reg
);
  // Idle lines show the inverse of the last transfer; a read leaves cmd_wdata held
  initial begin
    cmd_wr = 1'b0;
    cmd_rd = 1'b0;
    cmd_code = 8'hFF;
    cmd_wdata = 16'hA5A5;
  end

  task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
    @(negedge mclk);
    cmd_wr = 1'b1;
    cmd_code = code;
    cmd_wdata = data;
    @(negedge mclk);
    cmd_wr = 1'b0;
    cmd_code = ~code;
    cmd_wdata = ~data;
  endtask : write_reg

  task automatic read_reg(input logic [7:0] code, output logic [15:0] data,
                          output logic valid);
    @(negedge mclk);
    cmd_rd = 1'b1;
    cmd_code = code;
    @(negedge mclk);
    // Answer stands for one cycle after the read edge: take it now
    data = rd_data_reg;
    valid = rd_valid_reg;
    cmd_rd = 1'b0;
    cmd_code = ~code;
  endtask : read_reg
endmodule : pmbus_host_model

// ===== verification/test_output_overvoltage_fault_handler.sv
`timescale 1ns/10ps
module test_output_overvoltage_fault_handler import ovf_pkg::*;;
  localparam int UNIT = 8;
  logic mclk, reset_n, cmd_wr, cmd_rd, rd_valid_reg, fault_clear;
  logic control_pin_on, operation_off, bias_lost, other_fault;
  logic output_enable_reg, ov_fault_flag_reg, en_prev;
  logic [7:0] cmd_code;
  logic [15:0] cmd_wdata, rd_data_reg, vout_meas;
  logic [2:0] attempts_reg;
  int mismatches = 0;
  int checked = 0;
  int cyc = 0;
  int rises = 0;
  int gap = 0;
  int last_rise = 0;

  ov_fault_handler #(.UNIT_CYCLES(UNIT)) u_dut (.mclk(mclk),
    .reset_n(reset_n), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data_reg(rd_data_reg),
    .rd_valid_reg(rd_valid_reg), .vout_meas(vout_meas),
    .control_pin_on(control_pin_on), .operation_off(operation_off),
    .bias_lost(bias_lost), .other_fault(other_fault),
    .fault_clear(fault_clear), .output_enable_reg(output_enable_reg),
    .ov_fault_flag_reg(ov_fault_flag_reg), .attempts_reg(attempts_reg));
  pmbus_host_model u_host (.mclk(mclk), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd),
    .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rd_data_reg(rd_data_reg),
    .rd_valid_reg(rd_valid_reg));

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  // Each output rise is one restart; the gap is attempt start to start
  always @(posedge mclk) begin
    cyc++;
    if (output_enable_reg === 1'b1 && en_prev !== 1'b1) begin
      rises++;
      gap = cyc - last_rise;
      last_rise = cyc;
    end
    en_prev = output_enable_reg;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic final_report;
    $display("checked=%0d mismatches=%0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report

  task automatic cycles(input int n);
    repeat (n) @(negedge mclk);
  endtask : cycles

  task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp);
    logic [15:0] d;
    logic v;
    u_host.read_reg(code, d, v);
    check({15'h0, v}, 16'h0001);
    check(d, exp);
  endtask : rd_chk

  task automatic recover;
    vout_meas = 16'h0000;
    fault_clear = 1'b1;
    cycles(2);
    fault_clear = 1'b0;
    cycles(3);
    check({15'h0, ov_fault_flag_reg}, 16'h0000);
    check({13'h0, attempts_reg}, 16'h0000);
  endtask : recover

  task automatic test_regs;
    rd_chk(CMD_OV_LIMIT, OV_LIMIT_RESET);
    rd_chk(CMD_OV_ACTION, {8'h00, OV_ACTION_RESET});
    u_host.write_reg(CMD_OV_LIMIT, 16'h1234);
    u_host.write_reg(8'h42, 16'h5555);
    rd_chk(CMD_OV_LIMIT, 16'h1234);
    rd_chk(8'h42, RD_DATA_NONE);
    u_host.write_reg(CMD_OV_ACTION, 16'hABCD);
    rd_chk(CMD_OV_ACTION, 16'h00CD);
  endtask : test_regs

  task automatic test_threshold;
    u_host.write_reg(CMD_OV_LIMIT, 16'h0100);
    u_host.write_reg(CMD_OV_ACTION, 16'h0000);
    vout_meas = 16'h0100;
    cycles(4);
    check({15'h0, ov_fault_flag_reg}, 16'h0000);
    vout_meas = 16'h0101;
    cycles(4);
    check({15'h0, ov_fault_flag_reg}, 16'h0001);
    check({15'h0, output_enable_reg}, 16'h0001);
    // Reserved response codes must not shut the output down
    u_host.write_reg(CMD_OV_ACTION, 16'h00C8);
    cycles(4);
    check({15'h0, output_enable_reg}, 16'h0001);
    u_host.write_reg(CMD_OV_ACTION, 16'h0048);
    cycles(4);
    check({15'h0, output_enable_reg}, 16'h0001);
    recover();
  endtask : test_threshold

  task automatic test_no_retry;
    u_host.write_reg(CMD_OV_ACTION, {8'h00, RESP_DISABLE, RETRY_NONE, 3'h1});
    rises = 0;
    vout_meas = 16'h0200;
    cycles(3);
    check({15'h0, output_enable_reg}, 16'h0000);
    vout_meas = 16'h0000;
    cycles(6 * UNIT);
    check(16'(rises), 16'h0000);
    recover();
    check({15'h0, output_enable_reg}, 16'h0001);
  endtask : test_no_retry

  task automatic test_retries;
    int d;
    for (int n = 1; n <= 6; n++) begin
      d = 2 - n % 2;
      u_host.write_reg(CMD_OV_ACTION,
                       {8'h00, RESP_DISABLE, 3'(n), 3'(d)});
      rises = 0;
      vout_meas = 16'h0200;
      cycles(n * d * UNIT + 20);
      check(16'(rises), 16'(n));
      check({13'h0, attempts_reg}, 16'(n));
      check({15'h0, output_enable_reg}, 16'h0000);
      if (n > 1) check(16'(gap), 16'(d * UNIT));
      recover();
    end
  endtask : test_retries

  task automatic test_forever;
    logic [3:0] offs;
    for (int k = 0; k < 4; k++) begin
      u_host.write_reg(CMD_OV_ACTION,
                       {8'h00, RESP_DISABLE, RETRY_FOREVER, 3'h1});
      rises = 0;
      vout_meas = 16'h0200;
      cycles(12 * UNIT);
      check(16'(rises > 8), 16'h0001);
      offs = 4'b0001 << k;
      operation_off = offs[0];
      bias_lost = offs[1];
      other_fault = offs[2];
      control_pin_on = !offs[3];
      cycles(5);
      rises = 0;
      cycles(5 * UNIT);
      check(16'(rises), 16'h0000);
      check({15'h0, output_enable_reg}, 16'h0000);
      check({13'h0, attempts_reg}, 16'h0000);
      {operation_off, bias_lost, other_fault} = 3'h0;
      control_pin_on = 1'b1;
      recover();
    end
  endtask : test_forever

  // Longest expected run is about 1150 cycles
  initial begin
    #(6000 * 50);
    mismatches++;
    final_report();
  end

  initial begin
    reset_n = 1'b0;
    fault_clear = 1'b0;
    vout_meas = 16'h0000;
    control_pin_on = 1'b1;
    {operation_off, bias_lost, other_fault} = 3'h0;
    repeat (20) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    cycles(10);
    test_regs();
    test_threshold();
    test_no_retry();
    test_retries();
    test_forever();
    final_report();
  end
endmodule : test_output_overvoltage_fault_handler
